// ---- rtl/mrr_pkg.sv ----
`default_nettype none
package mrr_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 20_000_000;
  localparam int BOOT_TIME_S = 30;
  localparam int BOOT_CYCLES_DEF = BOOT_TIME_S * CLK_HZ;
  localparam int CONN_TMO_MS = 1000;
  localparam int CONN_TMO_CYCLES_DEF = CONN_TMO_MS * (CLK_HZ / 1000);
  localparam int SUP_TMO_MS = 5000;
  localparam int SUP_TMO_CYCLES_DEF = SUP_TMO_MS * (CLK_HZ / 1000);

  // ------------------------------------------------------------
  // alias block and stored configuration layout
  // ------------------------------------------------------------
  localparam int ALIAS_COUNT = 50;
  localparam logic [15:0] ALIAS_BASE = 16'h1389;
  localparam logic [15:0] ALIAS_END = ALIAS_BASE + 16'(ALIAS_COUNT);
  localparam logic [15:0] TARGET_NONE = 16'h0000;
  localparam logic [5:0] CFG_FIRST_IDX = 6'h00;
  localparam logic [5:0] CFG_SUP_IDX = 6'h32;
  localparam int CFG_SUP_BIT = 0;

  typedef enum logic [4:0] {
    ST_BOOT = 5'h01,
    ST_LOAD = 5'h02,
    ST_IDLE = 5'h04,
    ST_ACC  = 5'h08,
    ST_WAIT = 5'h10
  } mrr_state_e;

endpackage : mrr_pkg
`default_nettype wire

// ---- rtl/mrr_tmo_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface mrr_tmo_if;
  logic connOpen;
  logic activity;
  logic supEn;
  logic connTmo;
  logic supTmo;
  modport ctrl (output connOpen, output activity, output supEn,
                input connTmo, input supTmo);
  modport timer (input connOpen, input activity, input supEn,
                 output connTmo, output supTmo);
endinterface : mrr_tmo_if
`default_nettype wire

// ---- rtl/mrr_timeout.sv ----
`timescale 1ns/1ps
`default_nettype none
module mrr_timeout
  import mrr_pkg::*;
#(
  parameter int CONN_CYCLES = CONN_TMO_CYCLES_DEF,
  parameter int SUP_CYCLES = SUP_TMO_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst,
  mrr_tmo_if.timer t
);

  localparam logic [31:0] CONN_LIMIT = 32'(CONN_CYCLES);
  localparam logic [31:0] SUP_LIMIT = 32'(SUP_CYCLES);

  logic [31:0] connCnt_reg;
  logic [31:0] supCnt_reg;

  // ------------------------------------------------------------
  // per-connection timer: idle time inside one open socket
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || !t.connOpen || t.activity) begin
      connCnt_reg <= 32'h0000_0000;
    end else if (connCnt_reg != CONN_LIMIT) begin
      connCnt_reg <= connCnt_reg + 32'h0000_0001;
    end
  end

  // ------------------------------------------------------------
  // supervisory timer: keeps counting while no socket is open
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || !t.supEn || t.activity) begin
      supCnt_reg <= 32'h0000_0000;
    end else if (supCnt_reg != SUP_LIMIT) begin
      supCnt_reg <= supCnt_reg + 32'h0000_0001;
    end
  end

  assign t.connTmo = (connCnt_reg == CONN_LIMIT);
  assign t.supTmo = (supCnt_reg == SUP_LIMIT);

  conn_expire_a: assert property (@(posedge clk) disable iff (rst)
    (t.connOpen && !t.activity && connCnt_reg == CONN_LIMIT - 32'h1)
    |=> t.connTmo)
    else $error("connection timeout did not expire on time");

  sup_gap_a: assert property (@(posedge clk) disable iff (rst)
    (t.supEn && !t.activity && !t.connOpen
     && supCnt_reg == SUP_LIMIT - 32'h1) |=> t.supTmo)
    else $error("supervisory timeout lost across connection gap");

endmodule : mrr_timeout
`default_nettype wire

// ---- rtl/mrr_remap.sv ----
`timescale 1ns/1ps
`default_nettype none
module mrr_remap
  import mrr_pkg::*;
#(
  parameter int BOOT_CYCLES = BOOT_CYCLES_DEF,
  parameter int CONN_CYCLES = CONN_TMO_CYCLES_DEF,
  parameter int SUP_CYCLES = SUP_TMO_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic cfgCommit,
  output logic [5:0] cfgAddr,
  input wire logic [15:0] cfgData,
  input wire logic cmdValid,
  input wire logic cmdWrite,
  input wire logic [15:0] cmdStart,
  input wire logic [6:0] cmdQty,
  output logic cmdReady,
  input wire logic wrValid,
  input wire logic [15:0] wrData,
  output logic wrReady,
  output logic rdValid,
  output logic [15:0] rdData,
  output logic drvReq,
  output logic drvWrite,
  output logic [15:0] drvAddr,
  output logic [15:0] drvWdata,
  input wire logic drvAck,
  input wire logic [15:0] drvRdata,
  input wire logic connOpen,
  output logic bootBusy,
  output logic supEnabled,
  output logic timeoutFlag
);

  localparam logic [31:0] BOOT_LAST = 32'(BOOT_CYCLES - 1);

  mrr_state_e state_reg;
  logic [31:0] bootCnt_reg;
  logic [15:0] remapTable [ALIAS_COUNT];
  logic [15:0] startAddr_reg;
  logic [6:0] qty_reg;
  logic [6:0] wordCnt_reg;
  logic writeMode_reg;
  logic [15:0] curAddr, target;
  logic [5:0] aliasIdx;
  logic inAlias, zeroHit, procWord, lastWord, cmdTake, advance;
  mrr_tmo_if tmo ();

  // ------------------------------------------------------------
  // address translation of the current word
  // ------------------------------------------------------------
  assign curAddr = startAddr_reg + {9'h000, wordCnt_reg};
  assign inAlias = (curAddr >= ALIAS_BASE) && (curAddr < ALIAS_END);
  assign aliasIdx = 6'(curAddr - ALIAS_BASE);
  assign target = inAlias ? remapTable[aliasIdx] : curAddr;
  assign zeroHit = inAlias && (target == TARGET_NONE);
  assign procWord = (state_reg == ST_ACC)
                    && (!writeMode_reg || (wrValid && wrReady));
  assign lastWord = (wordCnt_reg == qty_reg - 7'h01);
  assign cmdTake = (state_reg == ST_IDLE) && cmdReady && cmdValid
                   && (cmdQty != 7'h00) && !cfgCommit;
  assign advance = !cfgCommit && ((procWord && zeroHit)
                   || ((state_reg == ST_WAIT) && drvAck));

  // ------------------------------------------------------------
  // main sequence: boot, load, serve
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || cfgCommit) begin
      state_reg <= ST_BOOT;
    end else begin
      case (state_reg)
        ST_BOOT: begin
          if (bootCnt_reg == BOOT_LAST) begin
            state_reg <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (cfgAddr == CFG_SUP_IDX) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (cmdTake) begin
            state_reg <= ST_ACC;
          end
        end
        ST_ACC: begin
          if (procWord && !zeroHit) begin
            state_reg <= ST_WAIT;
          end else if (advance && lastWord) begin
            state_reg <= ST_IDLE;
          end
        end
        ST_WAIT: begin
          if (advance) begin
            state_reg <= lastWord ? ST_IDLE : ST_ACC;
          end
        end
        default: begin
          state_reg <= ST_BOOT;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || cfgCommit || state_reg != ST_BOOT) begin
      bootCnt_reg <= 32'h0000_0000;
    end else begin
      bootCnt_reg <= bootCnt_reg + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || cfgCommit) begin
      bootBusy <= 1'b1;
    end else begin
      bootBusy <= (state_reg == ST_BOOT) || (state_reg == ST_LOAD);
    end
  end

  // ------------------------------------------------------------
  // configuration load, only reached after a boot
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || state_reg != ST_LOAD) begin
      cfgAddr <= CFG_FIRST_IDX;
    end else if (cfgAddr != CFG_SUP_IDX) begin
      cfgAddr <= cfgAddr + 6'h01;
    end
  end

  generate
    for (genvar i = 0; i < ALIAS_COUNT; i++) begin : g_entry
      always_ff @(posedge clk) begin
        if (state_reg == ST_LOAD && cfgAddr == 6'(i)) begin
          remapTable[i] <= cfgData;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst || cfgCommit) begin
      supEnabled <= 1'b0;
    end else if (state_reg == ST_LOAD && cfgAddr == CFG_SUP_IDX) begin
      supEnabled <= cfgData[CFG_SUP_BIT];
    end
  end

  // ------------------------------------------------------------
  // transaction bookkeeping
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      startAddr_reg <= 16'h0000;
      qty_reg <= 7'h01;
      writeMode_reg <= 1'b0;
    end else if (cmdTake) begin
      startAddr_reg <= cmdStart;
      qty_reg <= cmdQty;
      writeMode_reg <= cmdWrite;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || cmdTake) begin
      wordCnt_reg <= 7'h00;
    end else if (advance && !lastWord) begin
      wordCnt_reg <= wordCnt_reg + 7'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || cfgCommit) begin
      cmdReady <= 1'b0;
    end else if (cmdTake) begin
      cmdReady <= 1'b0;
    end else begin
      cmdReady <= (state_reg == ST_IDLE)
                  || (advance && lastWord);
    end
  end

  always_ff @(posedge clk) begin
    if (rst || cfgCommit) begin
      wrReady <= 1'b0;
    end else if (cmdTake) begin
      wrReady <= cmdWrite;
    end else if (advance && !lastWord) begin
      wrReady <= writeMode_reg;
    end else if (wrValid && wrReady) begin
      wrReady <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // drive-side access and read return
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst || cfgCommit) begin
      drvReq <= 1'b0;
      drvWrite <= 1'b0;
      drvAddr <= 16'h0000;
      drvWdata <= 16'h0000;
    end else if (procWord && !zeroHit) begin
      drvReq <= 1'b1;
      drvWrite <= writeMode_reg;
      drvAddr <= target;
      drvWdata <= writeMode_reg ? wrData : 16'h0000;
    end else if (drvAck) begin
      drvReq <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdValid <= 1'b0;
      rdData <= 16'h0000;
    end else begin
      rdValid <= advance && !writeMode_reg;
      // zero-target reads answer zero without touching the drive
      rdData <= zeroHit ? 16'h0000 : drvRdata;
    end
  end

  // ------------------------------------------------------------
  // timeout supervision
  // ------------------------------------------------------------
  assign tmo.connOpen = connOpen;
  assign tmo.activity = cmdTake;
  assign tmo.supEn = supEnabled;

  mrr_timeout #(
    .CONN_CYCLES(CONN_CYCLES),
    .SUP_CYCLES(SUP_CYCLES)
  ) u_timeout (
    .clk(clk),
    .rst(rst),
    .t(tmo.timer)
  );

  always_ff @(posedge clk) begin
    if (rst) begin
      timeoutFlag <= 1'b0;
    end else begin
      timeoutFlag <= tmo.connTmo || tmo.supTmo;
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  zero_read_a: assert property (@(posedge clk) disable iff (rst)
    (procWord && zeroHit && !writeMode_reg && !cfgCommit)
    |=> rdValid && rdData == 16'h0000 && !drvReq)
    else $error("zero-target read not answered with zero");
  zero_write_a: assert property (@(posedge clk) disable iff (rst)
    (procWord && zeroHit && writeMode_reg) |=> !drvReq)
    else $error("zero-target write reached the drive");
  alias_route_a: assert property (@(posedge clk) disable iff (rst)
    (procWord && inAlias && !zeroHit && !cfgCommit)
    |=> drvReq && drvAddr == remapTable[$past(aliasIdx)])
    else $error("alias not routed to its target");
  native_pass_a: assert property (@(posedge clk) disable iff (rst)
    (procWord && !inAlias && !cfgCommit)
    |=> drvReq && drvAddr == $past(curAddr))
    else $error("native register not passed through");
  word_step_a: assert property (@(posedge clk) disable iff (rst)
    (advance && !lastWord) |=> wordCnt_reg == $past(wordCnt_reg) + 7'h01)
    else $error("word index did not step by one");
  multi_word_a: assert property (@(posedge clk) disable iff (rst)
    (advance && !lastWord) |=> state_reg == ST_ACC)
    else $error("transfer ended before its quantity");
  commit_boot_a: assert property (@(posedge clk) disable iff (rst)
    cfgCommit |=> state_reg == ST_BOOT && !cmdReady && bootBusy
                  && !supEnabled)
    else $error("commit did not restart the block");
  timeout_flag_a: assert property (@(posedge clk) disable iff (rst)
    (tmo.connTmo || tmo.supTmo) |=> timeoutFlag)
    else $error("timeout expiry not indicated");

endmodule : mrr_remap
`default_nettype wire

// ---- testbench/mrr_drive_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mrr_drive_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic drvReq,
  input wire logic drvWrite,
  input wire logic [15:0] drvAddr,
  input wire logic [15:0] drvWdata,
  output logic drvAck,
  output logic [15:0] drvRdata
);
  logic [15:0] mem [0:255];
  logic [1:0] waitCnt = 2'h0;
  initial begin
    drvAck = 1'b0;
    drvRdata = 16'h0000;
    for (int i = 0; i < 256; i++) mem[i] = {8'ha5, 8'(i)};
  end
  // answer delay follows the low address bits: prompt and slow alike
  always @(posedge clk) begin
    if (rst || drvAck || !drvReq) begin
      drvAck <= 1'b0;
      waitCnt <= 2'h0;
      drvRdata <= ~drvRdata;
    end else if (waitCnt == drvAddr[1:0]) begin
      drvAck <= 1'b1;
      drvRdata <= mem[drvAddr[7:0]];
      if (drvWrite) mem[drvAddr[7:0]] <= drvWdata;
    end else begin
      waitCnt <= waitCnt + 2'h1;
      drvRdata <= ~drvRdata;
    end
  end
endmodule : mrr_drive_model
`default_nettype wire

// ---- testbench/test_modbus_register_remap.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_modbus_register_remap;
  localparam int BOOT = 20;
  localparam int CONN = 50;
  localparam int SUP = 80;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cfgCommit = 1'b0;
  logic cmdValid = 1'b0;
  logic cmdWrite = 1'b0;
  logic [15:0] cmdStart = 16'h0000;
  logic [6:0] cmdQty = 7'h00;
  logic wrValid = 1'b0;
  logic [15:0] wrData = 16'h0000;
  logic connOpen = 1'b0;
  logic togg = 1'b0;
  logic [5:0] cfgAddr;
  logic [15:0] cfgData, rdData, drvAddr, drvWdata, drvRdata;
  logic cmdReady, wrReady, rdValid, drvReq, drvWrite, drvAck;
  logic bootBusy, supEnabled, timeoutFlag;
  logic [15:0] cfgTab [0:50];
  logic [15:0] liveTab [0:50];
  logic [15:0] refMem [0:255];
  logic [15:0] expQ [$];
  int failCount = 0;
  int nChecks = 0;
  int seed = 54;
  int k;
  assign cfgData = cfgTab[cfgAddr];
  always #25 clk = ~clk;
  mrr_remap #(.BOOT_CYCLES(BOOT), .CONN_CYCLES(CONN), .SUP_CYCLES(SUP))
    mrr_remap_inst (.clk(clk), .rst(rst), .cfgCommit(cfgCommit),
    .cfgAddr(cfgAddr), .cfgData(cfgData), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdStart(cmdStart), .cmdQty(cmdQty),
    .cmdReady(cmdReady), .wrValid(wrValid), .wrData(wrData),
    .wrReady(wrReady), .rdValid(rdValid), .rdData(rdData),
    .drvReq(drvReq), .drvWrite(drvWrite), .drvAddr(drvAddr),
    .drvWdata(drvWdata), .drvAck(drvAck), .drvRdata(drvRdata),
    .connOpen(connOpen), .bootBusy(bootBusy), .supEnabled(supEnabled),
    .timeoutFlag(timeoutFlag));
  mrr_drive_model mrr_drive_model_inst (.clk(clk), .rst(rst),
    .drvReq(drvReq), .drvWrite(drvWrite), .drvAddr(drvAddr),
    .drvWdata(drvWdata), .drvAck(drvAck), .drvRdata(drvRdata));
  task automatic giveVerdict;
    if (failCount == 0 && nChecks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : giveVerdict
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    nChecks++;
    if (seen !== exp) begin
      failCount++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [15:0] route(input logic [15:0] a);
    if (a >= 16'h1389 && a < 16'h13bb) return liveTab[6'(a - 16'h1389)];
    return a;
  endfunction : route
  // sel 0: cmdReady, 1: wrReady, 2: timeoutFlag
  task automatic waitSig(input int sel, output int n);
    logic s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (togg) connOpen <= n[4];
      s = sel == 0 ? cmdReady : (sel == 1 ? wrReady : timeoutFlag);
    end while (s !== 1'b1 && n < 400);
    if (n >= 400) begin
      failCount++;
      giveVerdict();
    end
  endtask : waitSig
  task automatic xfer(input logic w, input logic [15:0] s,
                      input logic [6:0] q);
    logic [15:0] t, d;
    int n;
    for (int i = 0; i < q; i++) begin
      t = route(s + 16'(i));
      if (!w) expQ.push_back(t == 16'h0000 ? 16'h0000 : refMem[t[7:0]]);
    end
    cmdValid <= 1'b1;
    cmdWrite <= w;
    cmdStart <= s;
    cmdQty <= q;
    waitSig(0, n);
    cmdValid <= 1'b0;
    if (w) begin
      for (int i = 0; i < q; i++) begin
        d = 16'($random(seed));
        t = route(s + 16'(i));
        if (t != 16'h0000) refMem[t[7:0]] = d;
        wrValid <= 1'b1;
        wrData <= d;
        waitSig(1, n);
      end
      wrValid <= 1'b0;
    end
    waitSig(0, n);
    @(posedge clk);
    chk(16'(expQ.size()), 16'h0000);
  endtask : xfer
  always @(posedge clk) begin
    if (!rst && rdValid === 1'b1) begin
      chk(rdData, expQ.size() > 0 ? expQ.pop_front() : ~rdData);
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    failCount++;
    giveVerdict();
  end
  initial begin
    for (int i = 0; i < 256; i++) refMem[i] = {8'ha5, 8'(i)};
    for (int i = 0; i < 51; i++) cfgTab[i] = 16'h0000;
    cfgTab[0] = 16'h0010;
    cfgTab[1] = 16'h0020;
    cfgTab[2] = 16'h0030;
    cfgTab[4] = 16'h0005;
    cfgTab[49] = 16'h0050;
    liveTab = cfgTab;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    waitSig(0, k);
    chk(bootBusy, 1'b0);
    chk(supEnabled, 1'b0);
    // zero quantity is left untaken
    cmdValid <= 1'b1;
    repeat (3) @(posedge clk);
    chk({drvReq, cmdReady}, 2'h1);
    cmdValid <= 1'b0;
    @(posedge clk);
    xfer(1'b1, 16'h1389, 7'h05);
    xfer(1'b0, 16'h1389, 7'h05);
    xfer(1'b0, 16'h138b, 7'h03);
    xfer(1'b1, 16'h13b9, 7'h02);
    xfer(1'b0, 16'h13b8, 7'h04);
    xfer(1'b0, 16'h0010, 7'h01);
    xfer(1'b0, 16'h0005, 7'h01);
    repeat (150) @(posedge clk);
    chk(timeoutFlag, 1'b0);
    connOpen <= 1'b1;
    waitSig(2, k);
    chk(16'(k >= CONN - 2 && k <= CONN + 4), 16'h0001);
    connOpen <= 1'b0;
    repeat (3) @(posedge clk);
    chk(timeoutFlag, 1'b0);
    // stored table changes but the loaded one stays until restart
    cfgTab[1] = 16'h0070;
    xfer(1'b0, 16'h138a, 7'h01);
    cfgTab[0] = 16'h0060;
    cfgTab[50] = 16'h0001;
    cfgCommit <= 1'b1;
    @(posedge clk);
    cfgCommit <= 1'b0;
    repeat (2) @(posedge clk);
    chk({bootBusy, cmdReady}, 2'h2);
    waitSig(0, k);
    chk(16'(k > BOOT), 16'h0001);
    chk(supEnabled, 1'b1);
    liveTab = cfgTab;
    xfer(1'b0, 16'h1389, 7'h02);
    togg = 1'b1;
    waitSig(2, k);
    togg = 1'b0;
    connOpen <= 1'b0;
    chk(16'(k >= SUP - 14 && k <= SUP + 2), 16'h0001);
    xfer(1'b0, 16'h1389, 7'h01);
    chk(timeoutFlag, 1'b0);
    giveVerdict();
  end
endmodule : test_modbus_register_remap
`default_nettype wire
